/* File: core/rmmc_pkg.sv */
/*
   shared constants and types of the radio module mode controller.
   assumes a single 50 MHz system clock; every timing count here is
   derived from that rate.
*/
package rmmc_pkg;

   // system clock rate in hertz
   localparam int RMMC_CLK_HZ = 50_000_000;
   // settle time between an idle controller and the new mode, microseconds
   localparam int RMMC_SETTLE_US = 1000;
   // settle time as clock cycles, rounded down as a longest time
   localparam int RMMC_SETTLE_CYC = (RMMC_CLK_HZ / 1_000_000) * RMMC_SETTLE_US;
   // host side guard after the idle indicator rises, microseconds
   localparam int RMMC_HOST_GUARD_US = 2000;
   // host side guard as clock cycles
   localparam int RMMC_HOST_GUARD_CYC = (RMMC_CLK_HZ / 1_000_000) * RMMC_HOST_GUARD_US;
   // fixed serial rate used while in configuration mode
   localparam int RMMC_CFG_BAUD = 9600;
   // serial data width in bits
   localparam int RMMC_BYTE_W = 8;

   // operating modes, listed so that {high select, low select} is the code
   typedef enum logic [1:0] {
      RMMC_NORMAL,
      RMMC_WOR,
      RMMC_CONFIG,
      RMMC_SLEEP
   } rmmc_mode_t;

   // mode held from reset until the first switch
   localparam rmmc_mode_t RMMC_RESET_MODE = RMMC_NORMAL;
   // select synchroniser contents after reset
   localparam logic [1:0] RMMC_SEL_RESET = 2'h0;

   // one byte of a stream with its valid flag
   typedef struct packed {
      logic valid;
      logic [RMMC_BYTE_W-1:0] data;
   } rmmc_byte_t;

endpackage

/* File: core/rmmc_buf.sv */
/*
   two-entry buffer with valid and ready on both sides.
   assumes a synchronous active-high reset and one clock; the drain side
   may hold out_ready low for any time without losing a word.
*/
`timescale 1ns/1ps
module rmmc_buf #(
   parameter int W = 8 // word width
) (
   input wire logic sys_clk, // system clock
   input wire logic reset, // synchronous reset, active high
   input wire logic in_valid, // word offered on the fill side
   input wire logic [W-1:0] in_data, // word on the fill side
   output logic in_ready, // buffer has room, straight from a flop
   output logic out_valid, // head word present, straight from a flop
   output logic [W-1:0] out_data, // head word
   input wire logic out_ready // drain side takes the head word
);

   // whole state of the buffer
   typedef struct packed {
      logic v0; // head entry holds a word
      logic v1; // second entry holds a word
      logic [W-1:0] d0; // head word
      logic [W-1:0] d1; // second word
   } rmmc_buf_st_t;

   rmmc_buf_st_t st_r; // registered state
   rmmc_buf_st_t st_nxt; // next state
   logic push; // word enters this cycle
   logic pop; // word leaves this cycle

   // ready only while the second entry is free, so no word is ever dropped
   assign in_ready = !st_r.v1;
   assign out_valid = st_r.v0;
   assign out_data = st_r.d0;
   assign push = in_valid && !st_r.v1;
   assign pop = st_r.v0 && out_ready;

   // shift on pop, then append on push
   always_comb begin
      st_nxt = st_r;
      if (pop) begin
         st_nxt.d0 = st_r.d1;
         st_nxt.v0 = st_r.v1;
         st_nxt.v1 = 1'b0;
      end
      if (push) begin
         if (!st_nxt.v0) begin
            st_nxt.d0 = in_data;
            st_nxt.v0 = 1'b1;
         end else begin
            st_nxt.d1 = in_data;
            st_nxt.v1 = 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

/* File: core/rmmc_top.sv */
/*
   operating mode controller of a serial-to-radio module: select decode,
   deferred mode switching, idle indicator and the two byte paths.
   assumes the select pins and all stream inputs are synchronous to
   sys_clk, a radio engine and a serial engine around it, and a parameter
   loader that pulses reload_done when it has finished.
*/
// Overview of operation
// R1 - two selects pick one of four modes
// R2 - normal mode forwards host bytes to radio
// R3 - normal mode receives radio, outputs to serial
// R4 - normal mode accepts over-air configuration commands
// R5 - wake mode transmitter prepends wake preamble
// R6 - wake mode receives exactly like normal mode
// R7 - wake mode acts as wake sender or receiver
// R8 - config mode: radio off, registers via serial
// R9 - idle selection change applies after 1 ms
// R10 - pending radio transmission delays the switch
// R11 - pending serial output delays the switch
// R12 - switch only while idle indicator high
// R13 - streaming host data defers mode evaluation
// R14 - host waits 2 ms after idle rises
// R15 - sleep entered after pending data, within 1 ms
// R16 - busy switch completes automatically within 1 ms
// R17 - host may sleep, watch idle edge
// R18 - idle low whenever any busy condition holds; the code lowers it one edge after the condition appears
// R19 - leaving sleep reloads parameters, idle low
// R20 - config mode serial fixed 9600 8N1
// R21 - selects pass two synchroniser flops
// R22 - pending request applied once busy clears
`timescale 1ns/1ps
module rmmc_top
   import rmmc_pkg::*;
#(
   parameter int SETTLE_CYC = rmmc_pkg::RMMC_SETTLE_CYC // settle delay in cycles
) (
   input wire logic sys_clk, // system clock, 50 MHz
   input wire logic reset, // synchronous reset, active high
   input wire logic mode_select_low, // low mode select pin
   input wire logic mode_select_high, // high mode select pin
   input wire logic selfcheck_busy, // self-check in progress, level
   input wire logic reload_done, // parameter reload finished, pulse
   input wire rmmc_pkg::rmmc_byte_t host_rx, // byte from the serial receiver
   output logic host_rx_ready, // room for a host byte
   output rmmc_pkg::rmmc_byte_t radio_tx, // byte towards the radio engine
   input wire logic radio_tx_ready, // radio engine takes a byte
   input wire logic radio_tx_busy, // radio packet still on air, level
   input wire rmmc_pkg::rmmc_byte_t radio_rx, // byte from the radio receiver
   output logic radio_rx_ready, // room for a radio byte
   output rmmc_pkg::rmmc_byte_t ser_tx, // byte towards the serial sender
   input wire logic ser_tx_ready, // serial sender takes a byte
   input wire logic ser_tx_busy, // serial sender still shifting, level
   output rmmc_pkg::rmmc_byte_t cfg_rx, // host byte towards register access
   output logic idle_ind, // idle indicator pin, high when idle
   output rmmc_pkg::rmmc_mode_t mode_out, // mode in force
   output logic radio_tx_en, // radio transmitter enabled
   output logic radio_rx_en, // radio receiver enabled
   output logic wor_preamble_en, // prepend wake preamble to transmissions
   output logic ota_cfg_en, // over-air configuration commands accepted
   output logic cfg_access_en, // serial register access enabled
   output logic cfg_fixed_baud, // serial forced to fixed rate, 8N1
   output logic sleep_en, // deep sleep in force
   output logic reload_busy // parameter reload in progress
);

   import rmmc_pkg::*;

   // width of the settle counter
   localparam int CW = $clog2(SETTLE_CYC + 1);
   // last count of the settle delay
   localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYC - 1);

   // whole state of the controller
   typedef struct packed {
      logic [1:0] sel_s1; // first synchroniser stage, {high, low}
      logic [1:0] sel_s2; // second synchroniser stage
      rmmc_mode_t mode; // mode in force
      rmmc_mode_t req; // selection being timed
      logic [CW-1:0] cnt; // settle counter
      logic idle; // idle indicator
      logic reload; // parameter reload in progress
      logic tx_en; // radio transmit enable
      logic rx_en; // radio receive enable
      logic preamble; // wake preamble enable
      logic ota; // over-air configuration enable
      logic cfg; // register access enable
      logic baud; // fixed serial rate
      logic sleep; // deep sleep
   } rmmc_st_t;

   rmmc_st_t st_r; // registered state
   rmmc_st_t st_nxt; // next state
   rmmc_mode_t sel_mode; // decoded synchronised selection
   logic busy_now; // any busy condition this cycle
   logic tx_pop; // drain side of the host buffer accepts
   logic tx_valid; // host buffer head present
   logic [RMMC_BYTE_W-1:0] tx_data; // host buffer head
   logic rx_push; // radio byte offered to the receive buffer
   logic rx_valid; // receive buffer head present
   logic [RMMC_BYTE_W-1:0] rx_data; // receive buffer head
   logic host_rdy; // host buffer has room
   logic radio_rdy; // receive buffer has room

   // selection decode, {high, low} is the mode code
   assign sel_mode = rmmc_mode_t'(st_r.sel_s2); // [R1]

   // host bytes drain to radio in the radio modes, to register access in config
   always_comb begin
      tx_pop = 1'b0;
      if (st_r.tx_en) begin
         tx_pop = radio_tx_ready; // [R2]
      end else if (st_r.cfg) begin
         tx_pop = 1'b1; // [R8]
      end
   end

   // radio bytes are only taken while the receiver is enabled
   assign rx_push = radio_rx.valid && st_r.rx_en; // [R3] [R6]

   // host data buffer, serial in towards radio or register access
   rmmc_buf #(
      .W(RMMC_BYTE_W)
   ) u_tx_buf (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(host_rx.valid),
      .in_data(host_rx.data),
      .in_ready(host_rdy),
      .out_valid(tx_valid),
      .out_data(tx_data),
      .out_ready(tx_pop)
   );

   // received radio buffer, radio in towards the serial sender
   rmmc_buf #(
      .W(RMMC_BYTE_W)
   ) u_rx_buf (
      .sys_clk(sys_clk),
      .reset(reset),
      .in_valid(rx_push),
      .in_data(radio_rx.data),
      .in_ready(radio_rdy),
      .out_valid(rx_valid),
      .out_data(rx_data),
      .out_ready(ser_tx_ready)
   );

   // every condition that keeps the controller busy
   always_comb begin
      busy_now = 1'b0;
      if (tx_valid || host_rx.valid || radio_tx_busy) begin
         busy_now = 1'b1; // [R10] [R13]
      end
      if (rx_valid || ser_tx_busy) begin
         busy_now = 1'b1; // [R11]
      end
      if (st_r.reload || selfcheck_busy) begin
         busy_now = 1'b1; // [R18] [R19]
      end
   end

   // next state: synchroniser, deferred switch, mode flags
   always_comb begin
      st_nxt = st_r;
      // two-stage select synchroniser
      st_nxt.sel_s1 = {mode_select_high, mode_select_low}; // [R21]
      st_nxt.sel_s2 = st_r.sel_s1; // [R21]
      // idle indicator follows the busy conditions
      st_nxt.idle = !busy_now; // [R18]
      // reload ends on the loader's pulse
      if (st_r.reload && reload_done) begin
         st_nxt.reload = 1'b0; // [R19]
      end
      // switch timing
      if (sel_mode == st_r.mode) begin
         // nothing requested
         st_nxt.cnt = '0;
         st_nxt.req = sel_mode;
      end else if (sel_mode != st_r.req) begin
         // selection moved, restart the settle time
         st_nxt.cnt = '0;
         st_nxt.req = sel_mode;
      end else if (busy_now || !st_r.idle) begin
         // held until idle, the request stays registered
         st_nxt.cnt = '0; // [R12] [R13] [R22]
      end else if (st_r.cnt == SETTLE_LAST) begin
         // settle time over and still idle: apply
         st_nxt.cnt = '0;
         st_nxt.mode = st_r.req; // [R9] [R15] [R16] [R22]
         if (st_r.mode == RMMC_SLEEP) begin
            st_nxt.reload = 1'b1; // [R19]
         end
      end else begin
         // counting the settle time
         st_nxt.cnt = st_r.cnt + 1'b1; // [R9]
      end
      // mode flags follow the mode that will be in force
      st_nxt.tx_en = 1'b0;
      st_nxt.rx_en = 1'b0;
      st_nxt.preamble = 1'b0;
      st_nxt.ota = 1'b0;
      st_nxt.cfg = 1'b0;
      st_nxt.baud = 1'b0;
      st_nxt.sleep = 1'b0;
      unique case (st_nxt.mode)
         RMMC_NORMAL: begin
            // transparent both ways, over-air config accepted
            st_nxt.tx_en = 1'b1; // [R2]
            st_nxt.rx_en = 1'b1; // [R3]
            st_nxt.ota = 1'b1; // [R4]
         end
         RMMC_WOR: begin
            // wake sender adds the preamble, receiver as in normal mode
            st_nxt.tx_en = 1'b1; // [R7]
            st_nxt.rx_en = 1'b1; // [R6] [R7]
            st_nxt.preamble = 1'b1; // [R5]
         end
         RMMC_CONFIG: begin
            // radio off, register access at the fixed serial rate
            st_nxt.cfg = 1'b1; // [R8]
            st_nxt.baud = 1'b1; // [R20]
         end
         RMMC_SLEEP: begin
            // radio off, everything idle
            st_nxt.sleep = 1'b1;
         end
      endcase
   end

   // state register; self-check reload runs from reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_r.sel_s1 <= RMMC_SEL_RESET;
         st_r.sel_s2 <= RMMC_SEL_RESET;
         st_r.mode <= RMMC_RESET_MODE;
         st_r.req <= RMMC_RESET_MODE;
         st_r.cnt <= '0;
         st_r.idle <= 1'b0;
         st_r.reload <= 1'b1;
         st_r.tx_en <= 1'b0;
         st_r.rx_en <= 1'b0;
         st_r.preamble <= 1'b0;
         st_r.ota <= 1'b0;
         st_r.cfg <= 1'b0;
         st_r.baud <= 1'b0;
         st_r.sleep <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs straight from flops of this module or its buffers
   assign host_rx_ready = host_rdy;
   assign radio_rx_ready = radio_rdy;
   assign radio_tx.valid = tx_valid;
   assign radio_tx.data = tx_data;
   assign cfg_rx.valid = tx_valid;
   assign cfg_rx.data = tx_data;
   assign ser_tx.valid = rx_valid;
   assign ser_tx.data = rx_data;
   assign idle_ind = st_r.idle;
   assign mode_out = st_r.mode;
   assign radio_tx_en = st_r.tx_en;
   assign radio_rx_en = st_r.rx_en;
   assign wor_preamble_en = st_r.preamble;
   assign ota_cfg_en = st_r.ota;
   assign cfg_access_en = st_r.cfg;
   assign cfg_fixed_baud = st_r.baud;
   assign sleep_en = st_r.sleep;
   assign reload_busy = st_r.reload;

   // selection reaches the decoder two edges after the pins
   AST_SYNC_TWO_STAGES: assert property ( // [R21]
      @(posedge sys_clk) disable iff (reset)
      !$past(reset, 2) |-> st_r.sel_s2 == $past({mode_select_high, mode_select_low}, 2)
   ) else $error("select synchroniser is not two stages deep");

   // a busy condition pulls the idle indicator low at the next edge
   AST_IDLE_LOW_WHEN_BUSY: assert property ( // [R18]
      @(posedge sys_clk) disable iff (reset)
      busy_now |=> !idle_ind
   ) else $error("idle indicator high after a busy cycle");

   // the mode only changes while the indicator is high
   AST_SWITCH_ONLY_IDLE: assert property ( // [R12]
      @(posedge sys_clk) disable iff (reset)
      $changed(st_r.mode) |-> $past(st_r.idle) && $past(!busy_now)
   ) else $error("mode changed while busy");

   // no switch while host bytes or received bytes are pending
   AST_NO_SWITCH_PENDING: assert property ( // [R10]
      @(posedge sys_clk) disable iff (reset)
      (tx_valid || rx_valid || host_rx.valid) |=> $stable(st_r.mode)
   ) else $error("mode changed with data pending");

   // a switch follows a full settle count
   AST_SETTLE_TIME: assert property ( // [R9]
      @(posedge sys_clk) disable iff (reset)
      $changed(st_r.mode) |-> $past(st_r.cnt) == SETTLE_LAST
   ) else $error("mode applied before the settle time");

   // the applied mode is the synchronised selection
   AST_APPLIED_IS_SELECTED: assert property ( // [R1]
      @(posedge sys_clk) disable iff (reset)
      $changed(st_r.mode) |-> st_r.mode == rmmc_mode_t'($past(st_r.sel_s2))
   ) else $error("applied mode differs from selection");

   // configuration mode keeps the radio off and the serial rate fixed
   AST_CFG_RADIO_OFF: assert property ( // [R8]
      @(posedge sys_clk) disable iff (reset)
      st_r.mode == RMMC_CONFIG |-> !radio_tx_en && !radio_rx_en && cfg_access_en && cfg_fixed_baud
   ) else $error("configuration mode flags wrong");

   // wake mode adds the preamble and keeps the receiver on
   AST_WOR_FLAGS: assert property ( // [R5]
      @(posedge sys_clk) disable iff (reset)
      st_r.mode == RMMC_WOR |-> wor_preamble_en && radio_rx_en && radio_tx_en
   ) else $error("wake mode flags wrong");

   // normal mode is transparent with over-air configuration; the flags load
   // one edge after reset, so the first cycle out of reset is excused
   AST_NORMAL_FLAGS: assert property ( // [R3]
      @(posedge sys_clk) disable iff (reset)
      !$past(reset) && st_r.mode == RMMC_NORMAL
         |-> radio_rx_en && radio_tx_en && ota_cfg_en && !wor_preamble_en
   ) else $error("normal mode flags wrong");

   // leaving sleep starts a reload that holds the indicator low
   AST_SLEEP_EXIT_RELOAD: assert property ( // [R19]
      @(posedge sys_clk) disable iff (reset)
      ($past(st_r.mode) == RMMC_SLEEP && st_r.mode != RMMC_SLEEP) |-> reload_busy ##1 !idle_ind
   ) else $error("no reload after leaving sleep");

   // main scenarios
   COV_ENTER_CONFIG: cover property (
      @(posedge sys_clk) disable iff (reset)
      $changed(st_r.mode) && st_r.mode == RMMC_CONFIG
   );
   COV_SLEEP_AFTER_DATA: cover property (
      @(posedge sys_clk) disable iff (reset)
      tx_valid ##[1:1000] ($changed(st_r.mode) && st_r.mode == RMMC_SLEEP)
   );
   COV_LEAVE_SLEEP: cover property (
      @(posedge sys_clk) disable iff (reset)
      $past(st_r.mode) == RMMC_SLEEP && st_r.mode == RMMC_WOR
   );
   COV_RX_FORWARD: cover property (
      @(posedge sys_clk) disable iff (reset)
      ser_tx.valid && ser_tx_ready
   );

endmodule

/* File: verification/rmmc_host_model.sv */
/*
   host side model: drives the mode selects, offers serial bytes and
   takes bytes from the serial sender, with an optional stall.
   assumes inputs change on the falling clock edge.
*/
`timescale 1ns/1ps
module rmmc_host_model
   import rmmc_pkg::*;
#(
   parameter int GUARD_CYC = 16 // host guard after idle rises, shortened
) (
   input wire logic sys_clk, // system clock
   output logic mode_select_low, // low select pin
   output logic mode_select_high, // high select pin
   output rmmc_pkg::rmmc_byte_t host_rx, // byte offered to the device
   input wire logic host_rx_ready, // device takes the byte
   input wire rmmc_pkg::rmmc_byte_t ser_tx, // byte from the device
   output logic ser_tx_ready, // host takes a serial byte
   input wire logic idle_ind // idle indicator
);
   import rmmc_pkg::*;
   logic [7:0] out_q[$]; // bytes still to send
   logic [7:0] got_q[$]; // bytes received
   logic ser_stall = 1'b0; // host not taking serial bytes
   logic taken = 1'b0; // offered byte went in at the last edge
   logic [7:0] last = 8'h00; // last byte offered
   initial begin
      {mode_select_high, mode_select_low} = 2'h0;
      host_rx = '0;
      ser_tx_ready = 1'b1;
   end
   // handshakes are judged on the rising edge
   always @(posedge sys_clk) begin
      taken <= host_rx.valid && host_rx_ready;
      if (ser_tx.valid && ser_tx_ready) got_q.push_back(ser_tx.data);
   end
   // a byte stays offered until taken; an idle line shows the inverse
   always @(negedge sys_clk) begin
      if (taken) void'(out_q.pop_front());
      ser_tx_ready = !ser_stall;
      if (out_q.size() > 0) begin
         host_rx = '{valid: 1'b1, data: out_q[0]};
         last = out_q[0];
      end else begin
         host_rx = '{valid: 1'b0, data: ~last};
      end
   end
   // polite hosts wait for a steady idle, others switch at once
   task automatic select(input rmmc_mode_t m, input bit polite);
      int n;
      n = 0;
      while (polite && n < GUARD_CYC) begin
         @(posedge sys_clk);
         n = idle_ind ? n + 1 : 0;
      end
      @(negedge sys_clk);
      {mode_select_high, mode_select_low} = m;
   endtask
endmodule

/* File: verification/radio_module_mode_control_tb.sv */
/*
   self-checking bench of the mode controller, one task per scenario.
   assumes rmmc_top and the host model; settle count shortened to 8.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
   $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module radio_module_mode_control_tb;
   import rmmc_pkg::*;
   localparam int ST = 8; // shortened settle count
   logic sys_clk, reset, selfcheck_busy, reload_done, radio_tx_ready, radio_tx_busy;
   logic ser_tx_busy, mode_select_low, mode_select_high, host_rx_ready, radio_rx_ready;
   logic idle_ind, ser_tx_ready, radio_tx_en, radio_rx_en, wor_preamble_en, ota_cfg_en;
   logic cfg_access_en, cfg_fixed_baud, sleep_en, reload_busy;
   rmmc_byte_t host_rx, radio_tx, radio_rx, ser_tx, cfg_rx;
   rmmc_mode_t mode_out;
   int errors = 0;
   int n_checks = 0;
   logic [7:0] got_tx[$]; // bytes taken by the radio side
   logic [7:0] got_cfg[$]; // bytes taken by register access

   rmmc_top #(.SETTLE_CYC(ST)) dut (.sys_clk(sys_clk), .reset(reset),
      .mode_select_low(mode_select_low), .mode_select_high(mode_select_high),
      .selfcheck_busy(selfcheck_busy), .reload_done(reload_done), .host_rx(host_rx),
      .host_rx_ready(host_rx_ready), .radio_tx(radio_tx), .radio_tx_ready(radio_tx_ready),
      .radio_tx_busy(radio_tx_busy), .radio_rx(radio_rx), .radio_rx_ready(radio_rx_ready),
      .ser_tx(ser_tx), .ser_tx_ready(ser_tx_ready), .ser_tx_busy(ser_tx_busy),
      .cfg_rx(cfg_rx), .idle_ind(idle_ind), .mode_out(mode_out), .radio_tx_en(radio_tx_en),
      .radio_rx_en(radio_rx_en), .wor_preamble_en(wor_preamble_en), .ota_cfg_en(ota_cfg_en),
      .cfg_access_en(cfg_access_en), .cfg_fixed_baud(cfg_fixed_baud), .sleep_en(sleep_en),
      .reload_busy(reload_busy));

   rmmc_host_model host (.sys_clk(sys_clk), .mode_select_low(mode_select_low),
      .mode_select_high(mode_select_high), .host_rx(host_rx), .host_rx_ready(host_rx_ready),
      .ser_tx(ser_tx), .ser_tx_ready(ser_tx_ready), .idle_ind(idle_ind));

   // clock generator
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // records what the radio side and register access take
   always @(posedge sys_clk) begin
      if (radio_tx.valid === 1'b1 && radio_tx_ready === 1'b1 && radio_tx_en === 1'b1)
         got_tx.push_back(radio_tx.data);
      if (cfg_rx.valid === 1'b1 && cfg_access_en === 1'b1) got_cfg.push_back(cfg_rx.data);
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // waits for a mode, checks idle before it and the delay range
   task automatic wait_mode(input rmmc_mode_t m, input int lo, input int hi);
      int n;
      logic pi;
      n = 0;
      pi = 1'b0;
      while (mode_out !== m && n < hi + 4) begin
         pi = idle_ind;
         @(posedge sys_clk);
         #1;
         n++;
      end
      `CHK(mode_out, m)
      `CHK(pi, 1'b1)
      `CHK(n >= lo && n <= hi, 1'b1)
   endtask

   task automatic chk_flags(input rmmc_mode_t m);
      `CHK(radio_tx_en, m < RMMC_CONFIG)
      `CHK(radio_rx_en, m < RMMC_CONFIG)
      `CHK(wor_preamble_en, m == RMMC_WOR)
      `CHK(cfg_access_en, m == RMMC_CONFIG)
      `CHK(cfg_fixed_baud, m == RMMC_CONFIG)
      `CHK(sleep_en, m == RMMC_SLEEP)
      `CHK(ota_cfg_en, m == RMMC_NORMAL)
   endtask

   // parameter loader finishes; idle rises two edges later
   task automatic pulse_reload();
      @(negedge sys_clk);
      reload_done = 1'b1;
      @(negedge sys_clk);
      reload_done = 1'b0;
      @(posedge sys_clk);
      #1;
      `CHK(idle_ind, 1'b1)
   endtask

   task automatic go(input rmmc_mode_t m);
      logic was_sleep;
      was_sleep = (mode_out === RMMC_SLEEP);
      host.select(m, 1'b1);
      wait_mode(m, ST, ST + 6);
      chk_flags(m);
      if (was_sleep) begin
         `CHK(reload_busy, 1'b1)
         @(posedge sys_clk);
         #1;
         `CHK(idle_ind, 1'b0)
         pulse_reload();
      end
   endtask

   task automatic send_radio(input logic [7:0] b);
      int n;
      n = 0;
      @(negedge sys_clk);
      radio_rx = '{valid: 1'b1, data: b};
      while (!(radio_rx_ready === 1'b1 && radio_rx_en === 1'b1) && n < 50) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      radio_rx = '{valid: 1'b0, data: ~b};
   endtask

   // holds a switch back while one busy source is up
   task automatic hold_then(input rmmc_mode_t m, input rmmc_mode_t now);
      host.select(m, 1'b0);
      repeat (3 * ST) @(posedge sys_clk);
      #1;
      `CHK(mode_out, now)
      `CHK(idle_ind, 1'b0)
   endtask

   task automatic t_reset();
      @(posedge sys_clk);
      #1;
      `CHK(idle_ind, 1'b0)
      `CHK(reload_busy, 1'b1)
      @(posedge sys_clk);
      #1;
      `CHK(mode_out, RMMC_RESET_MODE)
      chk_flags(RMMC_NORMAL);
      pulse_reload();
   endtask

   task automatic t_busy();
      for (int i = 0; i < 3; i++) begin
         @(negedge sys_clk);
         {selfcheck_busy, ser_tx_busy, radio_tx_busy} = 3'h1 << i;
         hold_then(RMMC_WOR, RMMC_NORMAL);
         @(negedge sys_clk);
         {selfcheck_busy, ser_tx_busy, radio_tx_busy} = 3'h0;
         wait_mode(RMMC_WOR, ST, ST + 6);
         go(RMMC_NORMAL);
      end
   endtask

   task automatic t_host();
      @(negedge sys_clk);
      radio_tx_ready = 1'b0;
      for (int i = 0; i < 3; i++) host.out_q.push_back(8'ha0 + i[7:0]);
      hold_then(RMMC_CONFIG, RMMC_NORMAL);
      `CHK(host_rx_ready, 1'b0)
      `CHK(host.out_q.size(), 1)
      @(negedge sys_clk);
      radio_tx_ready = 1'b1;
      wait_mode(RMMC_CONFIG, ST, 3 * ST);
      `CHK(got_tx.size(), 3)
      for (int i = 0; i < 3; i++) `CHK(got_tx[i], 8'ha0 + i[7:0])
      host.out_q.push_back(8'h5c);
      repeat (4) @(posedge sys_clk);
      `CHK(got_cfg.size(), 1)
      `CHK(got_cfg[0], 8'h5c)
      `CHK(got_tx.size(), 3)
      go(RMMC_NORMAL);
   endtask

   task automatic t_sleep();
      @(negedge sys_clk);
      radio_tx_ready = 1'b0;
      host.out_q.push_back(8'h3e);
      hold_then(RMMC_SLEEP, RMMC_NORMAL);
      @(negedge sys_clk);
      radio_tx_ready = 1'b1;
      wait_mode(RMMC_SLEEP, ST, ST + 8);
      `CHK(got_tx[$], 8'h3e)
      chk_flags(RMMC_SLEEP);
      go(RMMC_NORMAL);
   endtask

   task automatic t_radio();
      go(RMMC_WOR);
      @(negedge sys_clk);
      host.ser_stall = 1'b1;
      send_radio(8'h71);
      send_radio(8'h72);
      `CHK(radio_rx_ready, 1'b0)
      hold_then(RMMC_CONFIG, RMMC_WOR);
      @(negedge sys_clk);
      host.ser_stall = 1'b0;
      wait_mode(RMMC_CONFIG, ST, 3 * ST);
      `CHK(host.got_q.size(), 2)
      `CHK(host.got_q[0], 8'h71)
      `CHK(host.got_q[1], 8'h72)
   endtask

   // main sequence
   initial begin
      reset = 1'b1;
      {selfcheck_busy, reload_done, radio_tx_busy, ser_tx_busy} = 4'h0;
      radio_tx_ready = 1'b1;
      radio_rx = '0;
      repeat (4) @(negedge sys_clk);
      reset = 1'b0;
      t_reset();
      go(RMMC_WOR);
      go(RMMC_CONFIG);
      go(RMMC_SLEEP);
      go(RMMC_WOR);
      go(RMMC_NORMAL);
      t_busy();
      t_host();
      t_sleep();
      t_radio();
      wrap_up();
   end

   // watchdog: the scenarios need a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      wrap_up();
   end
endmodule
